// *** rtl/lfs_pkg.sv ***
// Constants for the loopback frame builder and self-test reporter
package lfs_pkg;
    // Frame layout, in bytes from the first destination address byte
    localparam int LFS_ADDR_BYTES = 6;
    localparam int LFS_HDR_BYTES = 14;
    localparam int LFS_SAP_BYTES = 3;
    localparam int LFS_TEXT_BYTES = 31;
    localparam int LFS_PAT_BYTES = 1100;
    localparam int LFS_DATA_BYTES = 1134;
    localparam int LFS_FRAME_BYTES = LFS_HDR_BYTES + LFS_DATA_BYTES;
    localparam logic [15:0] LFS_TYPE_LEN = 16'h046e;
    localparam logic [7:0] LFS_SAP0 = 8'h00;
    localparam logic [7:0] LFS_SAP1 = 8'h01;
    localparam logic [7:0] LFS_SAP2 = 8'h3e;
    // Text layout: fixed head, twelve hex digits, fixed tail
    localparam int LFS_TEXT_HEAD = 12;
    localparam int LFS_TEXT_HEX = 12;
    localparam logic [12*8-1:0] LFS_HEAD_STR =
        96'h48_50_33_30_30_30_5f_4e_4f_44_45_5f;
    localparam logic [7*8-1:0] LFS_TAIL_STR = 56'h5f_54_45_53_54_2e_5f;
    localparam logic [7:0] LFS_PAT_START = 8'h00;
    // Failure codes shown on the LEDs H..N
    localparam logic [6:0] LFS_CODE_LOOP = 7'h2e;
    localparam logic [6:0] LFS_CODE_CMD = 7'h7a;
    localparam logic [6:0] LFS_CODE_R0 = 7'h7b;
    localparam logic [6:0] LFS_CODE_STACK = 7'h7c;
    localparam logic [6:0] LFS_CODE_NMI = 7'h7d;
    localparam logic [6:0] LFS_CODE_INT = 7'h7e;
    localparam logic [6:0] LFS_CODE_RESET = 7'h7f;
    // Indicator flash half period
    localparam int LFS_CLK_MHZ = 100;
    localparam int LFS_FLASH_HALF_MS = 250;
    localparam int LFS_FLASH_CYCLES = LFS_FLASH_HALF_MS * 1000 * LFS_CLK_MHZ;
    // Reporter states
    typedef enum logic [1:0] {
        LFS_ST_IDLE = 2'b00,
        LFS_ST_RUN = 2'b01,
        LFS_ST_FAIL = 2'b10
    } lfs_state_e;
endpackage

// *** rtl/lfs_frame_gen.sv ***
// Loopback test frame byte generator
module lfs_frame_gen
    import lfs_pkg::*;
(
    input wire logic ref_clk, // 100 MHz clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [47:0] station_addr, // Own station address
    input wire logic start, // Pulse: begin one frame
    input wire logic tx_ready, // Network controller takes byte
    output logic tx_valid, // Byte on tx_data is valid
    output logic [7:0] tx_data, // Frame byte
    output logic tx_last, // Last byte of frame
    output logic busy // Frame in progress
);

    typedef struct packed {
        logic busy;
        logic [10:0] idx;
        logic [7:0] data;
        logic last;
    } lfs_gen_s;

    lfs_gen_s st_reg;
    lfs_gen_s st_next;

    ////////////////////////////////////////////////////////////////////////
    // Nibble to upper-case ASCII hex digit
    function automatic logic [7:0] hex_char(input logic [3:0] n);
        hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction

    // Frame byte at a given index
    function automatic logic [7:0] frame_byte(input logic [10:0] i,
                                              input logic [47:0] a);
        int k;
        k = int'(i);
        frame_byte = 8'h00;
        if (k < LFS_ADDR_BYTES) begin
            frame_byte = a[47 - 8*k -: 8];
        end else if (k < 2*LFS_ADDR_BYTES) begin
            frame_byte = a[47 - 8*(k - LFS_ADDR_BYTES) -: 8];
        end else if (k == 2*LFS_ADDR_BYTES) begin
            frame_byte = LFS_TYPE_LEN[15:8];
        end else if (k == 2*LFS_ADDR_BYTES + 1) begin
            frame_byte = LFS_TYPE_LEN[7:0];
        end else if (k < LFS_HDR_BYTES + LFS_SAP_BYTES) begin
            k = k - LFS_HDR_BYTES;
            frame_byte = (k == 0) ? LFS_SAP0 :
                         (k == 1) ? LFS_SAP1 : LFS_SAP2;
        end else if (k < LFS_HDR_BYTES + LFS_SAP_BYTES + LFS_TEXT_BYTES) begin
            k = k - LFS_HDR_BYTES - LFS_SAP_BYTES;
            if (k < LFS_TEXT_HEAD) begin
                frame_byte = LFS_HEAD_STR[95 - 8*k -: 8];
            end else if (k < LFS_TEXT_HEAD + LFS_TEXT_HEX) begin
                frame_byte = hex_char(a[47 - 4*(k - LFS_TEXT_HEAD) -: 4]);
            end else begin
                k = k - LFS_TEXT_HEAD - LFS_TEXT_HEX;
                frame_byte = LFS_TAIL_STR[55 - 8*k -: 8];
            end
        end else begin
            k = k - LFS_HDR_BYTES - LFS_SAP_BYTES - LFS_TEXT_BYTES;
            frame_byte = LFS_PAT_START + k[7:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state: load first byte on start, advance on each accepted byte
    always_comb begin
        st_next = st_reg;
        if (!st_reg.busy) begin
            if (start) begin
                st_next.busy = 1'b1;
                st_next.idx = 11'd0;
                st_next.data = frame_byte(11'd0, station_addr);
                st_next.last = 1'b0;
            end
        end else if (tx_ready) begin
            if (st_reg.last) begin
                st_next.busy = 1'b0;
                st_next.last = 1'b0;
            end else begin
                st_next.idx = st_reg.idx + 11'd1;
                st_next.data = frame_byte(st_next.idx, station_addr);
                st_next.last = (int'(st_next.idx) == LFS_FRAME_BYTES - 1);
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Preamble and check sequence are added by the network controller
    assign tx_valid = st_reg.busy;
    assign tx_data = st_reg.data;
    assign tx_last = st_reg.last;
    assign busy = st_reg.busy;

endmodule // lfs_frame_gen

// *** rtl/lfs_selftest.sv ***
// Self-test failure reporter and loopback frame control
module lfs_selftest
    import lfs_pkg::*;
#(
    parameter int FLASH_CYCLES = LFS_FLASH_CYCLES // Indicator half period
) (
    input wire logic ref_clk, // 100 MHz clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [47:0] station_addr, // Address from station PROM
    input wire logic test_start, // Pulse: processor begins self-test
    input wire logic [6:0] subtest_code, // Running subtest number
    input wire logic subtest_valid, // Pulse: subtest_code updated
    input wire logic test_done, // Pulse: whole sequence passed
    input wire logic cmd_clear_fail, // Pulse: command word not cleared
    input wire logic result_bit0_bad, // Pulse: result register bit 0 bad
    input wire logic stack_underflow, // Pulse: processor stack underflow
    input wire logic nmi_unexpected, // Pulse: unexpected NMI
    input wire logic irq_unexpected, // Pulse: unexpected interrupt
    input wire logic loop_start, // Pulse: begin medium loopback
    input wire logic loop_ok, // Pulse: frame came back intact
    input wire logic loop_bad, // Pulse: frame lost or corrupt
    input wire logic test_switch_b, // Pin: reset switch, low = pressed
    input wire logic mau_present, // Pin: transceiver attached
    input wire logic tx_ready, // Network controller takes byte
    output logic tx_valid, // Frame byte valid
    output logic [7:0] tx_data, // Frame byte
    output logic tx_last, // Last frame byte
    output logic [6:0] code_led, // LEDs H..N, bit 6 is H
    output logic self_test_indicator_led, // Indicator LED, lit = 1
    output logic restart_test, // Pulse: rerun self-test
    output logic failed // Failure code latched
);

    typedef struct packed {
        lfs_state_e state;
        logic [6:0] code;
        logic ind;
        logic [31:0] flash_cnt;
        logic sw_s1;
        logic sw_s2;
        logic mau_s1;
        logic mau_s2;
        logic restart;
        logic gen_go;
    } lfs_top_s;

    lfs_top_s st_reg;
    lfs_top_s st_next;
    logic gen_busy;

    ////////////////////////////////////////////////////////////////////////
    // Frame generator for the medium loopback subtest
    lfs_frame_gen u_gen (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .station_addr(station_addr),
        .start(st_reg.gen_go),
        .tx_ready(tx_ready),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_last(tx_last),
        .busy(gen_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state: synchronise pins, track progress, latch failures
    always_comb begin
        st_next = st_reg;
        st_next.sw_s1 = ~test_switch_b;
        st_next.sw_s2 = st_reg.sw_s1;
        st_next.mau_s1 = mau_present;
        st_next.mau_s2 = st_reg.mau_s1;
        st_next.restart = 1'b0;
        st_next.gen_go = 1'b0;
        case (st_reg.state)
            LFS_ST_IDLE: begin
                // Code and indicator hold: 7F after reset, 00 after a pass
                if (test_start) begin
                    st_next.state = LFS_ST_RUN;
                    st_next.flash_cnt = 32'd0;
                end
            end
            LFS_ST_RUN: begin
                // Indicator flashes while the sequence progresses
                if (int'(st_reg.flash_cnt) >= FLASH_CYCLES - 1) begin
                    st_next.flash_cnt = 32'd0;
                    st_next.ind = ~st_reg.ind;
                end else begin
                    st_next.flash_cnt = st_reg.flash_cnt + 32'd1;
                end
                if (subtest_valid) begin
                    st_next.code = subtest_code;
                end
                // Failure priority: lowest of codes 7A..7E wins, loopback code 2E comes last
                if (cmd_clear_fail) begin
                    st_next.code = LFS_CODE_CMD;
                    st_next.state = LFS_ST_FAIL;
                end else if (result_bit0_bad) begin
                    st_next.code = LFS_CODE_R0;
                    st_next.state = LFS_ST_FAIL;
                end else if (stack_underflow) begin
                    st_next.code = LFS_CODE_STACK;
                    st_next.state = LFS_ST_FAIL;
                end else if (nmi_unexpected) begin
                    st_next.code = LFS_CODE_NMI;
                    st_next.state = LFS_ST_FAIL;
                end else if (irq_unexpected) begin
                    st_next.code = LFS_CODE_INT;
                    st_next.state = LFS_ST_FAIL;
                end else if (loop_start && !st_reg.mau_s2) begin
                    st_next.code = LFS_CODE_LOOP;
                    st_next.state = LFS_ST_FAIL;
                end else if (loop_bad) begin
                    st_next.code = LFS_CODE_LOOP;
                    st_next.state = LFS_ST_FAIL;
                end else if (loop_start && !gen_busy) begin
                    st_next.code = LFS_CODE_LOOP;
                    st_next.gen_go = 1'b1;
                end else if (test_done || loop_ok) begin
                    if (st_reg.sw_s2) begin
                        st_next.restart = 1'b1;
                        st_next.flash_cnt = 32'd0;
                    end else begin
                        st_next.state = LFS_ST_IDLE;
                        st_next.code = 7'h00;
                    end
                end
                if (st_next.state == LFS_ST_FAIL) begin
                    st_next.ind = 1'b1;
                end
                if (st_next.state == LFS_ST_IDLE) begin
                    st_next.ind = 1'b0;
                end
            end
            LFS_ST_FAIL: begin
                // Code and steady indicator hold until the next reset
                st_next.ind = 1'b1;
            end
            default: begin
                st_next.state = LFS_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg.state <= LFS_ST_IDLE;
            st_reg.code <= LFS_CODE_RESET;
            st_reg.ind <= 1'b1;
            st_reg.flash_cnt <= 32'd0;
            st_reg.sw_s1 <= 1'b0;
            st_reg.sw_s2 <= 1'b0;
            st_reg.mau_s1 <= 1'b0;
            st_reg.mau_s2 <= 1'b0;
            st_reg.restart <= 1'b0;
            st_reg.gen_go <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs from state flip-flops; failed is a decode of the state register
    assign code_led = st_reg.code;
    assign self_test_indicator_led = st_reg.ind;
    assign restart_test = st_reg.restart;
    assign failed = (st_reg.state == LFS_ST_FAIL);

endmodule // lfs_selftest

// *** sim/lfs_selftest_properties.sv ***
// Concurrent checks on the self-test reporter ports
module lfs_selftest_properties
    import lfs_pkg::*;
#(
    parameter int FLASH_CYCLES = 4 // Indicator half period
) (
    input wire logic ref_clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic [47:0] station_addr, // Station address
    input wire logic cmd_clear_fail, // Command word event
    input wire logic result_bit0_bad, // Result bit event
    input wire logic stack_underflow, // Stack event
    input wire logic nmi_unexpected, // NMI event
    input wire logic irq_unexpected, // Interrupt event
    input wire logic tx_ready, // Byte taken
    input wire logic tx_valid, // Byte valid
    input wire logic [7:0] tx_data, // Frame byte
    input wire logic tx_last, // Last byte
    input wire logic [6:0] code_led, // Code LEDs
    input wire logic self_test_indicator_led, // Indicator LED
    input wire logic failed // Failure latched
);
    logic [4:0] ev_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Events of the previous cycle, highest priority in bit 4
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_q <= 5'h00;
        end else begin
            ev_q <= {cmd_clear_fail, result_bit0_bad, stack_underflow,
                nmi_unexpected, irq_unexpected};
        end
    end
    a_cmd_code: assert property (
        $rose(failed) && ev_q[4] |-> code_led == 7'h7a)
        else $error("command word code wrong");
    a_result_code: assert property (
        $rose(failed) && ev_q[4:3] == 2'b01 |-> code_led == 7'h7b)
        else $error("result bit code wrong");
    a_stack_code: assert property (
        $rose(failed) && ev_q[4:2] == 3'b001 |-> code_led == 7'h7c)
        else $error("stack code wrong");
    a_nmi_code: assert property (
        $rose(failed) && ev_q[4:1] == 4'b0001 |-> code_led == 7'h7d)
        else $error("nmi code wrong");
    a_irq_code: assert property (
        $rose(failed) && ev_q == 5'b00001 |-> code_led == 7'h7e)
        else $error("interrupt code wrong");
    a_reset_code: assert property (
        $rose(rst_b) |-> code_led == 7'h7f && !failed)
        else $error("code after reset wrong");
    a_steady_led: assert property (
        failed |-> self_test_indicator_led)
        else $error("indicator not steady");
    a_fail_hold: assert property (
        failed |=> failed && $stable(code_led))
        else $error("failure code not held");
    a_first_byte: assert property (
        $rose(tx_valid) |-> tx_data == station_addr[47:40])
        else $error("first frame byte wrong");
    a_byte_hold: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("stalled byte changed");
    a_frame_end: assert property (
        tx_valid && tx_ready && tx_last |=> !tx_valid)
        else $error("frame runs past last byte");
endmodule // lfs_selftest_properties

// *** sim/lfs_mac_model.sv ***
// Network controller model taking frame bytes with stalls
module lfs_mac_model
    import lfs_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic tx_valid, // Byte offered
    input wire logic [7:0] tx_data, // Frame byte
    input wire logic tx_last, // Last byte
    output logic tx_ready // Byte taken
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got [0:LFS_FRAME_BYTES-1];
    int count;
    int last_idx;
    logic [1:0] phase;
    // Stores bytes, one stall cycle in three; preamble and check
    // sequence would wrap the stored bytes on the medium
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 0;
            last_idx <= -1;
            phase <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            tx_ready <= (phase != 2'h2);
            if (tx_valid && tx_ready) begin
                if (count < LFS_FRAME_BYTES) got[count] <= tx_data;
                if (tx_last) last_idx <= count;
                count <= count + 1;
            end
        end
    end
endmodule // lfs_mac_model

// *** sim/lfs_selftest_tb.sv ***
// Self-checking bench for the self-test reporter
module lfs_selftest_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lfs_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [47:0] station_addr = 48'h09af3c5e71b2;
    logic test_start = 1'b0;
    logic [6:0] subtest_code = 7'h00;
    logic subtest_valid = 1'b0;
    logic test_done = 1'b0;
    logic [4:0] ev = 5'h00;
    logic loop_start = 1'b0;
    logic loop_bad = 1'b0;
    logic loop_ok = 1'b0;
    logic test_switch_b = 1'b1;
    logic mau_present = 1'b1;
    logic tx_ready, tx_valid, tx_last, restart_test, failed, ind;
    logic [7:0] tx_data;
    logic [6:0] code_led;
    int n_fail = 0;
    int tests_run = 0;
    lfs_selftest #(.FLASH_CYCLES(4)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
        .station_addr(station_addr), .test_start(test_start),
        .subtest_code(subtest_code), .subtest_valid(subtest_valid),
        .test_done(test_done), .cmd_clear_fail(ev[4]),
        .result_bit0_bad(ev[3]), .stack_underflow(ev[2]),
        .nmi_unexpected(ev[1]), .irq_unexpected(ev[0]),
        .loop_start(loop_start), .loop_ok(loop_ok), .loop_bad(loop_bad),
        .test_switch_b(test_switch_b), .mau_present(mau_present),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .code_led(code_led),
        .self_test_indicator_led(ind), .restart_test(restart_test),
        .failed(failed));
    lfs_mac_model mac (.ref_clk(ref_clk), .rst_b(rst_b),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready));
    ////////////////////////////////////////////////////////////////////
    // Clock generation
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // Comparison and verdict helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Compared %0d, mismatched %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Expected frame byte at index i
    function automatic logic [7:0] exp_byte(input int i);
        logic [3:0] nib;
        nib = station_addr[47-4*(i-29) -: 4];
        if (i < 12) return station_addr[47-8*(i%6) -: 8];
        if (i < 14) return 8'(LFS_DATA_BYTES >> (8 * (13 - i)));
        if (i < 17) return (i == 14) ? 8'h00 : (i == 15) ? 8'h01 : 8'h3e;
        if (i < 29) return LFS_HEAD_STR[95-8*(i-17) -: 8];
        if (i < 41) return {4'h0, nib} + ((nib < 4'ha) ? 8'h30 : 8'h37);
        if (i < 48) return LFS_TAIL_STR[55-8*(i-41) -: 8];
        return 8'(i - 48);
    endfunction
    // Reset and start sequences
    task automatic do_reset();
        @(posedge ref_clk) rst_b <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
    endtask
    task automatic start_test();
        @(posedge ref_clk) test_start <= 1'b1;
        @(posedge ref_clk) test_start <= 1'b0;
    endtask
    task automatic pulse_loop();
        @(posedge ref_clk) loop_start <= 1'b1;
        @(posedge ref_clk) loop_start <= 1'b0;
    endtask
    // Each of the five processor failure events shows its code with a steady indicator
    task automatic t_fail_codes();
        for (int k = 0; k < 5; k++) begin
            do_reset();
            @(negedge ref_clk) chk(code_led, 7'h7f);
            start_test();
            @(posedge ref_clk) subtest_valid <= 1'b1;
            subtest_code <= 7'h05;
            @(posedge ref_clk) subtest_valid <= 1'b0;
            ev <= 5'h01 << k;
            @(negedge ref_clk) chk(code_led, 7'h05);
            @(posedge ref_clk) ev <= 5'h00;
            @(negedge ref_clk);
            chk(code_led, 7'h7e - 7'(k));
            chk(failed, 1'b1);
            repeat (12) @(negedge ref_clk) chk(ind, 1'b1);
        end
    endtask
    // Frame content, then a bad loopback result
    task automatic t_frame();
        int i;
        do_reset();
        start_test();
        pulse_loop();
        for (i = 0; i < 3000 && mac.count < LFS_FRAME_BYTES; i++)
            @(negedge ref_clk);
        chk(16'(mac.count), 16'(LFS_FRAME_BYTES));
        for (i = 0; i < 17; i++)
            chk(mac.got[i], exp_byte(i));
        for (i = 17; i < 48; i++)
            chk(mac.got[i], exp_byte(i));
        for (i = 48; i < LFS_FRAME_BYTES; i++)
            chk(mac.got[i], exp_byte(i));
        chk(16'(mac.last_idx), 16'(LFS_FRAME_BYTES - 1));
        @(posedge ref_clk) loop_bad <= 1'b1;
        @(posedge ref_clk) loop_bad <= 1'b0;
        @(negedge ref_clk) chk(code_led, 7'h2e);
    endtask
    // Missing transceiver fails the loopback without sending
    task automatic t_no_mau();
        @(posedge ref_clk) mau_present <= 1'b0;
        do_reset();
        start_test();
        pulse_loop();
        @(negedge ref_clk) chk({failed, code_led}, 8'hae);
        repeat (5) @(negedge ref_clk) chk(tx_valid, 1'b0);
    endtask
    // Held switch reruns the test, then keeps the failure shown
    task automatic t_switch_loop();
        int seen;
        seen = 0;
        @(posedge ref_clk) test_switch_b <= 1'b0;
        do_reset();
        start_test();
        @(posedge ref_clk) test_done <= 1'b1;
        @(posedge ref_clk) test_done <= 1'b0;
        repeat (4) @(negedge ref_clk) if (restart_test === 1'b1) seen++;
        chk(16'(seen), 16'h0001);
        @(posedge ref_clk) ev <= 5'h04;
        @(posedge ref_clk) ev <= 5'h00;
        repeat (8) begin
            @(negedge ref_clk);
            chk({failed, code_led}, 8'hfc);
        end
    endtask
    // A pass with the switch released goes idle; later events are ignored
    task automatic t_pass();
        @(posedge ref_clk) test_switch_b <= 1'b1;
        do_reset();
        start_test();
        @(posedge ref_clk) loop_ok <= 1'b1;
        @(posedge ref_clk) loop_ok <= 1'b0;
        ev <= 5'h01;
        @(posedge ref_clk) ev <= 5'h00;
        repeat (4) begin
            @(negedge ref_clk);
            chk({restart_test, failed, ind, code_led}, 10'h000);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        t_fail_codes();
        t_frame();
        t_no_mau();
        t_pass();
        t_switch_loop();
        tally_and_finish();
    end
endmodule // lfs_selftest_tb

bind lfs_selftest lfs_selftest_properties #(.FLASH_CYCLES(FLASH_CYCLES))
    u_props (.ref_clk(ref_clk), .rst_b(rst_b), .station_addr(station_addr),
    .cmd_clear_fail(cmd_clear_fail), .result_bit0_bad(result_bit0_bad),
    .stack_underflow(stack_underflow), .nmi_unexpected(nmi_unexpected),
    .irq_unexpected(irq_unexpected), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .code_led(code_led), .failed(failed),
    .self_test_indicator_led(self_test_indicator_led));
